/* File: rtl/usb_iface_module_status_flags.sv */
// usb interface module status, flag and line control register group
`timescale 1ns/1ns
// Overview of operation
// [RL1] on-the-go status bits 5:0 mirror transceiver session indications, zero at reset
// [RL2] serial control bits 6:4 read differential, d-minus and d-plus receive state
// [RL3] serial control bits 3 and 2 drive se0 request and transmit data
// [RL4] serial control bit 1 is active-low transmit enable, resets to one
// [RL5] serial control bit 0 selects full/low-speed serial mode
// [RL6] flag 6 sets on good token carrying the configured device address
// [RL7] flags 5, 4, 3 set on line state se0, k and j
// [RL8] flag 2 sets when a data packet fails its crc16 check
// [RL9] flags 1 and 0 follow rx active and rx error inputs
// [RL10] non-held flags 6:2 clear when the next packet begins
// [RL11] held flags stay set until software writes one to clear
// [RL12] non-held flags are overwritten by later signal changes
// [RL13] four 8-bit masks route flags onto output ports by or
// [RL14] 11-bit frame counter readable and writable, zero at reset
// [RL15] last packet identifier captured into read-only bits 3:0
// [RL16] last endpoint number in bits 3:0, valid in bit 4
// [RL17] tagged endpoints appear on receive port ored with 0x10
// [RL18] 32-bit on-the-go flag mask register, zero at reset
// [RL19] power signal register: valid bit 8, data byte 7:0
// [RL20] token match uses the 7-bit device address register
// [RL21] any write to module reset register clears all internal state except read valid, serial control returns to 0x2
// [RL22] software uses 32-bit accesses as peripheral 1
// [RL23] top bit of each mask byte selects nothing
module usb_iface_module_status_flags
    import usb_iface_module_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // register port, 32-bit word access
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // transceiver status
    input wire usb_iface_module_otg_t otg_i,
    input wire usb_iface_module_rxline_t rxline_i,
    input wire logic [1:0] line_state_i,
    input wire logic rx_active_i,
    input wire logic rx_error_i,
    // packet decode events
    input wire usb_iface_module_pkt_t pkt_i,
    // transceiver serial control
    output usb_iface_module_txctl_t txctl_o,
    // flag ports and receive endpoint port
    output logic [USB_IFACE_MODULE_NPORTS-1:0] flag_ports_o,
    output logic [4:0] rx_ep_o,
    output logic rx_ep_valid_o
);
    // ****************************************
    // state
    // ****************************************
    usb_iface_module_state_t st_r;
    usb_iface_module_state_t st_nxt;
    logic [USB_IFACE_MODULE_NFLAGS-1:0] ev_set;
    logic [USB_IFACE_MODULE_NFLAGS-1:0] ev_live;
    logic [USB_IFACE_MODULE_NFLAGS-1:0] sw_clr;

    // word-aligned decode helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // the register port reads zero during a module reset write; everything but rvalid resets
    always_comb begin
        st_nxt = st_r;
        // level-following flags, the others only set on events
        ev_live = '0;
        ev_live[USB_IFACE_MODULE_FLG_RXACT] = rx_active_i; // see [RL9]
        ev_live[USB_IFACE_MODULE_FLG_RXERR] = rx_error_i; // see [RL9]
        ev_set = '0;
        ev_set[USB_IFACE_MODULE_FLG_TOKEN] = pkt_i.token_ok && (pkt_i.token_addr == st_r.dev_addr); // see [RL6] [RL20]
        ev_set[USB_IFACE_MODULE_FLG_SE0] = line_state_i == USB_IFACE_MODULE_LS_SE0; // see [RL7]
        ev_set[USB_IFACE_MODULE_FLG_K] = line_state_i == USB_IFACE_MODULE_LS_K; // see [RL7]
        ev_set[USB_IFACE_MODULE_FLG_J] = line_state_i == USB_IFACE_MODULE_LS_J; // see [RL7]
        ev_set[USB_IFACE_MODULE_FLG_CRC] = pkt_i.crc16_fail; // see [RL8]
        ev_set = ev_set | ev_live;
        sw_clr = '0;
        if (reg_wr_i && hit(reg_addr_i, USB_IFACE_MODULE_OFS_FLAGS)) begin
            sw_clr = reg_wdata_i[USB_IFACE_MODULE_NFLAGS-1:0];
        end
        // flags: set wins over clear and over the packet-start clear
        for (int i = 0; i < USB_IFACE_MODULE_NFLAGS; i++) begin
            if (st_r.hold[i]) begin
                if (ev_set[i]) begin
                    st_nxt.flags[i] = 1'b1;
                end else if (sw_clr[i]) begin
                    st_nxt.flags[i] = 1'b0; // see [RL11]
                end
            end else if (i == USB_IFACE_MODULE_FLG_RXACT || i == USB_IFACE_MODULE_FLG_RXERR) begin
                st_nxt.flags[i] = ev_live[i]; // see [RL12]
            end else if (ev_set[i]) begin
                st_nxt.flags[i] = 1'b1;
            end else if (pkt_i.packet_start) begin
                st_nxt.flags[i] = 1'b0; // see [RL10] [RL12]
            end
        end
        // captured packet fields
        if (pkt_i.pid_valid) begin
            st_nxt.pid = pkt_i.pid; // see [RL15]
        end
        if (pkt_i.ep_valid) begin
            st_nxt.ep = pkt_i.ep; // see [RL16]
            st_nxt.ep_valid = 1'b1;
            st_nxt.rx_ep = st_r.ep_tag[pkt_i.ep] ? ({1'b0, pkt_i.ep} | USB_IFACE_MODULE_EP_TAG_OR)
                                                 : {1'b0, pkt_i.ep}; // see [RL17]
            st_nxt.rx_ep_valid = 1'b1;
        end else begin
            st_nxt.rx_ep_valid = 1'b0;
        end
        // transceiver status mirrors
        st_nxt.otg = otg_i; // see [RL1]
        st_nxt.rxline = rxline_i; // see [RL2]
        // register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                USB_IFACE_MODULE_OFS_DEV_ADDR: st_nxt.dev_addr = reg_wdata_i[6:0];
                USB_IFACE_MODULE_OFS_SERIAL: st_nxt.txctl = reg_wdata_i[3:0]; // see [RL3] [RL4] [RL5]
                USB_IFACE_MODULE_OFS_HOLD: st_nxt.hold = reg_wdata_i[USB_IFACE_MODULE_NFLAGS-1:0]; // see [RL11]
                USB_IFACE_MODULE_OFS_MASKS: st_nxt.masks = reg_wdata_i; // see [RL13]
                USB_IFACE_MODULE_OFS_FRAME: st_nxt.frame = reg_wdata_i[USB_IFACE_MODULE_FRAME_W-1:0]; // see [RL14]
                USB_IFACE_MODULE_OFS_EP_TAG: st_nxt.ep_tag = reg_wdata_i[USB_IFACE_MODULE_EP_W-1:0];
                USB_IFACE_MODULE_OFS_OTG_MASK: st_nxt.otg_mask = reg_wdata_i; // see [RL18]
                USB_IFACE_MODULE_OFS_PWRSIG: st_nxt.pwrsig = reg_wdata_i[8:0]; // see [RL19]
                default: st_nxt.dev_addr = st_r.dev_addr;
            endcase
        end
        // port routing uses the new flag values one cycle later
        for (int p = 0; p < USB_IFACE_MODULE_NPORTS; p++) begin
            st_nxt.ports[p] = |(st_r.flags & st_r.masks[p*USB_IFACE_MODULE_MASK_W +: USB_IFACE_MODULE_NFLAGS]); // see [RL13] [RL23]
        end
        // read data, unmapped reads return zero
        st_nxt.rvalid = reg_rd_i;
        st_nxt.rdata = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                USB_IFACE_MODULE_OFS_DEV_ADDR: st_nxt.rdata[6:0] = st_r.dev_addr;
                USB_IFACE_MODULE_OFS_OTG_STATUS: st_nxt.rdata[5:0] = st_r.otg;
                USB_IFACE_MODULE_OFS_SERIAL: st_nxt.rdata[6:0] = {st_r.rxline, st_r.txctl};
                USB_IFACE_MODULE_OFS_FLAGS: st_nxt.rdata[USB_IFACE_MODULE_NFLAGS-1:0] = st_r.flags;
                USB_IFACE_MODULE_OFS_HOLD: st_nxt.rdata[USB_IFACE_MODULE_NFLAGS-1:0] = st_r.hold;
                USB_IFACE_MODULE_OFS_MASKS: st_nxt.rdata = st_r.masks;
                USB_IFACE_MODULE_OFS_FRAME: st_nxt.rdata[USB_IFACE_MODULE_FRAME_W-1:0] = st_r.frame;
                USB_IFACE_MODULE_OFS_PID: st_nxt.rdata[3:0] = st_r.pid;
                USB_IFACE_MODULE_OFS_EP: st_nxt.rdata[4:0] = {st_r.ep_valid, st_r.ep}; // see [RL16]
                USB_IFACE_MODULE_OFS_EP_TAG: st_nxt.rdata[USB_IFACE_MODULE_EP_W-1:0] = st_r.ep_tag;
                USB_IFACE_MODULE_OFS_OTG_MASK: st_nxt.rdata = st_r.otg_mask;
                USB_IFACE_MODULE_OFS_PWRSIG: st_nxt.rdata[8:0] = st_r.pwrsig;
                default: st_nxt.rdata = '0;
            endcase
        end
        // module reset write clears all state except rvalid; txctl reloads its reset value
        if (reg_wr_i && hit(reg_addr_i, USB_IFACE_MODULE_OFS_RESET)) begin
            st_nxt = '0; // see [RL21]
            st_nxt.txctl = USB_IFACE_MODULE_SER_RST;
            st_nxt.rvalid = reg_rd_i;
        end
    end

    // state register
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= '0;
            st_r.txctl <= USB_IFACE_MODULE_SER_RST; // see [RL4]
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign reg_rdata_o = st_r.rdata;
    assign reg_rvalid_o = st_r.rvalid;
    assign txctl_o = st_r.txctl;
    assign flag_ports_o = st_r.ports;
    assign rx_ep_o = st_r.rx_ep;
    assign rx_ep_valid_o = st_r.rx_ep_valid;

    // ****************************************
    // assertions
    // ****************************************
    property p_otg_mirror;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !(reg_wr_i && reg_addr_i == USB_IFACE_MODULE_OFS_RESET) |=> st_r.otg == $past(otg_i);
    endproperty
    a_otg_mirror: assert property (p_otg_mirror) else $error("otg mirror wrong"); // see [RL1]
    property p_rxline;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !(reg_wr_i && reg_addr_i == USB_IFACE_MODULE_OFS_RESET) |=> st_r.rxline == $past(rxline_i);
    endproperty
    a_rxline: assert property (p_rxline) else $error("rx line mirror wrong"); // see [RL2]
    property p_serial_wr;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == USB_IFACE_MODULE_OFS_SERIAL |=> txctl_o == $past(reg_wdata_i[3:0]);
    endproperty
    a_serial_wr: assert property (p_serial_wr) else $error("serial control not written"); // see [RL3]
    property p_txen_rst;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == USB_IFACE_MODULE_OFS_RESET |=> txctl_o.tx_enable_low && !txctl_o.tx_serial_data;
    endproperty
    a_txen_rst: assert property (p_txen_rst) else $error("tx enable not reset high"); // see [RL4]
    property p_token;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        pkt_i.token_ok && pkt_i.token_addr == st_r.dev_addr && !(reg_wr_i && reg_addr_i == USB_IFACE_MODULE_OFS_RESET)
        |=> st_r.flags[USB_IFACE_MODULE_FLG_TOKEN];
    endproperty
    a_token: assert property (p_token) else $error("token flag not set"); // see [RL6]
    property p_crc;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        pkt_i.crc16_fail && !(reg_wr_i && reg_addr_i == USB_IFACE_MODULE_OFS_RESET) |=> st_r.flags[USB_IFACE_MODULE_FLG_CRC];
    endproperty
    a_crc: assert property (p_crc) else $error("crc flag not set"); // see [RL8]
    property p_hold;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        st_r.flags[USB_IFACE_MODULE_FLG_CRC] && st_r.hold[USB_IFACE_MODULE_FLG_CRC] && !reg_wr_i |=> st_r.flags[USB_IFACE_MODULE_FLG_CRC];
    endproperty
    a_hold: assert property (p_hold) else $error("held flag lost"); // see [RL11]
    property p_autoclr;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        pkt_i.packet_start && !st_r.hold[USB_IFACE_MODULE_FLG_CRC] && !pkt_i.crc16_fail |=> !st_r.flags[USB_IFACE_MODULE_FLG_CRC];
    endproperty
    a_autoclr: assert property (p_autoclr) else $error("flag not cleared on packet"); // see [RL10]
    property p_port;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !(reg_wr_i && reg_addr_i == USB_IFACE_MODULE_OFS_RESET)
        |=> flag_ports_o[0] == |($past(st_r.flags) & $past(st_r.masks[6:0]));
    endproperty
    a_port: assert property (p_port) else $error("port 0 routing wrong"); // see [RL13]
    property p_tag;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        pkt_i.ep_valid && st_r.ep_tag[pkt_i.ep] && !(reg_wr_i && reg_addr_i == USB_IFACE_MODULE_OFS_RESET)
        |=> rx_ep_o[4] && rx_ep_valid_o;
    endproperty
    a_tag: assert property (p_tag) else $error("tagged endpoint lacks 0x10"); // see [RL17]
endmodule

/* File: rtl/usb_iface_module_pkg.sv */
// package of constants and carrier types for the usb interface status block
package usb_iface_module_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] USB_IFACE_MODULE_OFS_RESET = 8'h00;
    localparam logic [7:0] USB_IFACE_MODULE_OFS_DEV_ADDR = 8'h08;
    localparam logic [7:0] USB_IFACE_MODULE_OFS_OTG_STATUS = 8'h14;
    localparam logic [7:0] USB_IFACE_MODULE_OFS_SERIAL = 8'h18;
    localparam logic [7:0] USB_IFACE_MODULE_OFS_FLAGS = 8'h1C;
    localparam logic [7:0] USB_IFACE_MODULE_OFS_HOLD = 8'h20;
    localparam logic [7:0] USB_IFACE_MODULE_OFS_MASKS = 8'h24;
    localparam logic [7:0] USB_IFACE_MODULE_OFS_FRAME = 8'h28;
    localparam logic [7:0] USB_IFACE_MODULE_OFS_PID = 8'h2C;
    localparam logic [7:0] USB_IFACE_MODULE_OFS_EP = 8'h30;
    localparam logic [7:0] USB_IFACE_MODULE_OFS_EP_TAG = 8'h34;
    localparam logic [7:0] USB_IFACE_MODULE_OFS_OTG_MASK = 8'h38;
    localparam logic [7:0] USB_IFACE_MODULE_OFS_PWRSIG = 8'h3C;
    // ****************************************
    // field positions and widths
    // ****************************************
    localparam int USB_IFACE_MODULE_NFLAGS = 7;
    localparam int USB_IFACE_MODULE_NPORTS = 4;
    localparam int USB_IFACE_MODULE_MASK_W = 8;
    localparam int USB_IFACE_MODULE_FRAME_W = 11;
    localparam int USB_IFACE_MODULE_EP_W = 16;
    localparam int USB_IFACE_MODULE_SER_RXDIFF = 6;
    localparam int USB_IFACE_MODULE_SER_RXDM = 5;
    localparam int USB_IFACE_MODULE_SER_RXDP = 4;
    localparam int USB_IFACE_MODULE_SER_TXSE0 = 3;
    localparam int USB_IFACE_MODULE_SER_TXDAT = 2;
    localparam int USB_IFACE_MODULE_SER_TXENN = 1;
    localparam int USB_IFACE_MODULE_SER_FSLS = 0;
    localparam int USB_IFACE_MODULE_FLG_TOKEN = 6;
    localparam int USB_IFACE_MODULE_FLG_SE0 = 5;
    localparam int USB_IFACE_MODULE_FLG_K = 4;
    localparam int USB_IFACE_MODULE_FLG_J = 3;
    localparam int USB_IFACE_MODULE_FLG_CRC = 2;
    localparam int USB_IFACE_MODULE_FLG_RXACT = 1;
    localparam int USB_IFACE_MODULE_FLG_RXERR = 0;
    localparam int USB_IFACE_MODULE_EP_VALID = 4;
    localparam int USB_IFACE_MODULE_PWR_VALID = 8;
    // ****************************************
    // line state codes and reset values
    // ****************************************
    localparam logic [1:0] USB_IFACE_MODULE_LS_SE0 = 2'h0;
    localparam logic [1:0] USB_IFACE_MODULE_LS_J = 2'h1;
    localparam logic [1:0] USB_IFACE_MODULE_LS_K = 2'h2;
    localparam logic [4:0] USB_IFACE_MODULE_EP_TAG_OR = 5'h10;
    localparam logic [3:0] USB_IFACE_MODULE_SER_RST = 4'h2;
    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic b_session_valid;
        logic id_ground;
        logic host_disconnect;
        logic vbus_valid;
        logic session_valid;
        logic session_end;
    } usb_iface_module_otg_t;
    typedef struct packed {
        logic rx_differential;
        logic rx_dminus;
        logic rx_dplus;
    } usb_iface_module_rxline_t;
    typedef struct packed {
        logic tx_single_ended_zero;
        logic tx_serial_data;
        logic tx_enable_low;
        logic fs_ls_serial_select;
    } usb_iface_module_txctl_t;
    typedef struct packed {
        logic packet_start;
        logic token_ok;
        logic [6:0] token_addr;
        logic crc16_fail;
        logic pid_valid;
        logic [3:0] pid;
        logic ep_valid;
        logic [3:0] ep;
    } usb_iface_module_pkt_t;
    typedef struct packed {
        logic [USB_IFACE_MODULE_NFLAGS-1:0] flags;
        logic [USB_IFACE_MODULE_NFLAGS-1:0] hold;
        logic [31:0] masks;
        logic [USB_IFACE_MODULE_FRAME_W-1:0] frame;
        logic [3:0] pid;
        logic ep_valid;
        logic [3:0] ep;
        logic [USB_IFACE_MODULE_EP_W-1:0] ep_tag;
        logic [31:0] otg_mask;
        logic [8:0] pwrsig;
        logic [6:0] dev_addr;
        usb_iface_module_txctl_t txctl;
        usb_iface_module_otg_t otg;
        usb_iface_module_rxline_t rxline;
        logic [31:0] rdata;
        logic rvalid;
        logic [USB_IFACE_MODULE_NPORTS-1:0] ports;
        logic [4:0] rx_ep;
        logic rx_ep_valid;
    } usb_iface_module_state_t;
endpackage

/* File: tb/usb_iface_module_xcvr_model.sv */
// transceiver and packet decoder stand-in for the status block
`timescale 1ns/1ns
module usb_iface_module_xcvr_model
    import usb_iface_module_pkg::*;
(
    // clock
    input wire logic clk_sys_i,
    // transceiver side
    output usb_iface_module_otg_t otg_o,
    output usb_iface_module_rxline_t rxline_o,
    output logic [1:0] line_state_o,
    output logic rx_active_o,
    output logic rx_error_o,
    output usb_iface_module_pkt_t pkt_o
);
    // ****
    // idle levels at time zero, line state shows no symbol
    // ****
    initial begin
        otg_o = '0;
        rxline_o = '0;
        line_state_o = 2'h3;
        rx_active_o = 1'b0;
        rx_error_o = 1'b0;
        pkt_o = '0;
    end
    // session and receive line levels
    task automatic set_status(input usb_iface_module_otg_t o, input usb_iface_module_rxline_t r);
        @(negedge clk_sys_i);
        otg_o = o;
        rxline_o = r;
    endtask
    // line state and receiver status levels
    task automatic set_line(input logic [1:0] ls, input logic act, input logic err);
        @(negedge clk_sys_i);
        line_state_o = ls;
        rx_active_o = act;
        rx_error_o = err;
    endtask
    // one-cycle strobe; stale fields flip so nothing is read outside its strobe
    task automatic send(input usb_iface_module_pkt_t p);
        @(negedge clk_sys_i);
        pkt_o = p;
        @(negedge clk_sys_i);
        pkt_o = {1'b0, 1'b0, ~p.token_addr, 1'b0, 1'b0, ~p.pid, 1'b0, ~p.ep};
    endtask
endmodule

/* File: tb/usb_iface_module_status_flags_test.sv */
// self-checking bench for the usb interface status and flag registers
`timescale 1ns/1ns
module usb_iface_module_status_flags_test;
    import usb_iface_module_pkg::*;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [31:0] reg_rdata_o;
    logic reg_rvalid_o;
    usb_iface_module_otg_t otg_i;
    usb_iface_module_rxline_t rxline_i;
    logic [1:0] line_state_i;
    logic rx_active_i;
    logic rx_error_i;
    usb_iface_module_pkt_t pkt_i;
    usb_iface_module_txctl_t txctl_o;
    logic [3:0] flag_ports_o;
    logic [4:0] rx_ep_o;
    logic rx_ep_valid_o;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int i;
    logic [7:0] t_a [8] = '{8'h20, 8'h24, 8'h28, 8'h34, 8'h38, 8'h3C, 8'h2C, 8'h44};
    logic [31:0] t_e [8] = '{32'h7F, 32'hFFFFFFFF, 32'h7FF, 32'hFFFF, 32'hFFFFFFFF,
        32'h1FF, 32'h0, 32'h0};
    logic [1:0] t_ls [3] = '{USB_IFACE_MODULE_LS_SE0, USB_IFACE_MODULE_LS_K, USB_IFACE_MODULE_LS_J};
    logic [31:0] t_f [3] = '{32'h20, 32'h10, 32'h08};
    usb_iface_module_pkt_t p_start = '{1'b1, 1'b0, 7'h0, 1'b0, 1'b0, 4'h0, 1'b0, 4'h0};
    // ****
    // design, transceiver model and clock
    // ****
    usb_iface_module_status_flags dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .otg_i(otg_i), .rxline_i(rxline_i), .line_state_i(line_state_i),
        .rx_active_i(rx_active_i), .rx_error_i(rx_error_i), .pkt_i(pkt_i),
        .txctl_o(txctl_o), .flag_ports_o(flag_ports_o), .rx_ep_o(rx_ep_o),
        .rx_ep_valid_o(rx_ep_valid_o));
    usb_iface_module_xcvr_model xcvr_u (.clk_sys_i(clk_sys_i), .otg_o(otg_i), .rxline_o(rxline_i),
        .line_state_o(line_state_i), .rx_active_o(rx_active_i), .rx_error_o(rx_error_i),
        .pkt_o(pkt_i));
    always #20 clk_sys_i = ~clk_sys_i;
    // hang guard, far above the roughly 170 cycles the tests need
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // ****
    // compare, register access and closing tasks
    // ****
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // whole 32-bit words only, no narrower access exists
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_sys_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
    endtask
    // rvalid comes one cycle after the strobe; bounded wait in case it is late
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        int k;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
        for (k = 0; k < 3 && reg_rvalid_o !== 1'b1; k++) begin
            @(negedge clk_sys_i);
        end
        check({31'h0, reg_rvalid_o}, 32'h1);
        check(reg_rdata_o, exp);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****
    // test sequence
    // ****
    initial begin
        repeat (16) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        check({28'h0, txctl_o}, 32'h2);
        rd(8'h18, 32'h2);
        rd(8'h14, 32'h0);
        for (i = 0; i < 8; i++) begin
            rd(t_a[i], 32'h0);
            wr(t_a[i], 32'hFFFFFFFF);
            rd(t_a[i], t_e[i]);
        end
        $display("test registers done");
        xcvr_u.set_status(6'h2A, 3'b101);
        rd(8'h14, 32'h2A);
        wr(8'h18, 32'hFFFFFFF5);
        rd(8'h18, 32'h55);
        check({28'h0, txctl_o}, 32'h5);
        wr(8'h18, 32'h0A);
        check({28'h0, txctl_o}, 32'hA);
        $display("test serial done");
        // port3 mask has only its top bit, which must select nothing
        wr(8'h20, 32'h0);
        wr(8'h24, 32'h80402004);
        wr(8'h08, 32'h15);
        for (i = 0; i < 3; i++) begin
            xcvr_u.set_line(t_ls[i], 1'b0, 1'b0);
            rd(8'h1C, t_f[i]);
            xcvr_u.set_line(2'h3, 1'b0, 1'b0);
            xcvr_u.send(p_start);
            rd(8'h1C, 32'h0);
        end
        xcvr_u.set_line(USB_IFACE_MODULE_LS_SE0, 1'b0, 1'b0);
        rd(8'h1C, 32'h20);
        check({28'h0, flag_ports_o}, 32'h2);
        xcvr_u.set_line(2'h3, 1'b1, 1'b1);
        xcvr_u.send(p_start);
        rd(8'h1C, 32'h03);
        xcvr_u.set_line(2'h3, 1'b0, 1'b0);
        rd(8'h1C, 32'h0);
        xcvr_u.send('{1'b0, 1'b0, 7'h0, 1'b1, 1'b0, 4'h0, 1'b0, 4'h0});
        rd(8'h1C, 32'h04);
        check({28'h0, flag_ports_o}, 32'h1);
        xcvr_u.send('{1'b1, 1'b1, 7'h15, 1'b0, 1'b0, 4'h0, 1'b0, 4'h0});
        rd(8'h1C, 32'h40);
        check({28'h0, flag_ports_o}, 32'h4);
        xcvr_u.send(p_start);
        xcvr_u.send('{1'b0, 1'b1, 7'h16, 1'b0, 1'b0, 4'h0, 1'b0, 4'h0});
        rd(8'h1C, 32'h0);
        wr(8'h20, 32'h04);
        xcvr_u.send('{1'b0, 1'b0, 7'h0, 1'b1, 1'b0, 4'h0, 1'b0, 4'h0});
        xcvr_u.send(p_start);
        rd(8'h1C, 32'h04);
        wr(8'h1C, 32'h04);
        rd(8'h1C, 32'h0);
        $display("test flags done");
        wr(8'h34, 32'h0008);
        xcvr_u.send('{1'b1, 1'b0, 7'h0, 1'b0, 1'b1, 4'hD, 1'b1, 4'h3});
        check({26'h0, rx_ep_valid_o, rx_ep_o}, 32'h33);
        rd(8'h2C, 32'hD);
        rd(8'h30, 32'h13);
        xcvr_u.send('{1'b1, 1'b0, 7'h0, 1'b0, 1'b1, 4'h9, 1'b1, 4'h5});
        check({26'h0, rx_ep_valid_o, rx_ep_o}, 32'h25);
        rd(8'h30, 32'h15);
        $display("test packet capture done");
        wr(8'h28, 32'h123);
        wr(8'h00, 32'h5A5A);
        rd(8'h28, 32'h0);
        rd(8'h30, 32'h0);
        rd(8'h24, 32'h0);
        check({28'h0, txctl_o}, 32'h2);
        $display("test module reset done");
        report_and_stop();
    end
endmodule
